// ==== include/lia_defines.vh ====
// register map, field layout, mode codes and timing constants of the logic input assertion block
// assumes a 100 MHz clock and a classic wishbone slave with 32-bit data
// Notes on behaviour
// - contact-close mode follows closed contact only
// - contact-open mode follows open contact only
// - virtual-on mode follows virtual on only
// - virtual-off mode follows virtual off only
// - closed-and-von needs both together
// - closed-and-voff needs both together
// - and modes stay off on one condition
// - alarm assertion raises message, led, relays
// - condition gone withdraws message, led, relays
// - each assertion logs one event
// - fourteen inputs, any one selectable as source
// - contact and virtual states readable as status
// - open-and-von needs both together
// - open-and-voff needs both together
// - or modes assert on either condition
`ifndef LIA_DEFINES_VH
`define LIA_DEFINES_VH

`define LIA_NUM_IN 14

// byte addresses
`define LIA_ADR_CTRL 8'h00
`define LIA_ADR_VIRT 8'h04
`define LIA_ADR_DELAY 8'h08
`define LIA_ADR_CONTACT 8'h0c
`define LIA_ADR_STATUS 8'h10
`define LIA_ADR_IRQ_STAT 8'h14
`define LIA_ADR_IRQ_MASK 8'h18
`define LIA_ADR_EVCNT 8'h1c
`define LIA_ADR_NAME 8'h20

// control register fields
`define LIA_CTRL_SRC_LSB 0
`define LIA_CTRL_SRC_MSB 3
`define LIA_CTRL_MODE_LSB 4
`define LIA_CTRL_MODE_MSB 7
`define LIA_CTRL_FUNC_LSB 8
`define LIA_CTRL_FUNC_MSB 9
`define LIA_CTRL_RLY_LSB 16
`define LIA_CTRL_RLY_MSB 20

// assertion modes
`define LIA_MODE_CLOSE 4'h0
`define LIA_MODE_OPEN 4'h1
`define LIA_MODE_VON 4'h2
`define LIA_MODE_VOFF 4'h3
`define LIA_MODE_C_AND_VON 4'h4
`define LIA_MODE_C_AND_VOFF 4'h5
`define LIA_MODE_O_AND_VON 4'h6
`define LIA_MODE_O_AND_VOFF 4'h7
`define LIA_MODE_C_OR_VON 4'h8
`define LIA_MODE_C_OR_VOFF 4'h9
`define LIA_MODE_O_OR_VON 4'ha
`define LIA_MODE_O_OR_VOFF 4'hb

// functions
`define LIA_FUNC_DISABLED 2'h0
`define LIA_FUNC_ALARM 2'h1

// delay tick of 10 ms, in clock cycles
`define LIA_TICK_NS 10000000
`define LIA_CLK_NS 10
`define LIA_TICK_CYC (`LIA_TICK_NS / `LIA_CLK_NS)

// irq status bits
`define LIA_IRQ_ASSERT 0
`define LIA_IRQ_RELEASE 1

`define LIA_CTRL_RST 32'h00000000
`define LIA_NAME_RST 32'h00000000

`endif

// ==== rtl/lia_sync.v ====
// two-flop synchroniser for a vector of field inputs
// assumes inputs are asynchronous to clk_i
`timescale 1ns/10ps
module lia_sync #(
	parameter W = 14
) (
	// clock and reset
	input wire clk_i,
	input wire rst_i,
	// data
	input wire [W-1:0] d_i,
	output wire [W-1:0] q_o
);
	reg [W-1:0] meta_ff;
	reg [W-1:0] sync_ff;
	always @(posedge clk_i) begin
		if (rst_i) begin
			meta_ff <= {W{1'b0}};
			sync_ff <= {W{1'b0}};
		end else begin
			meta_ff <= d_i;
			sync_ff <= meta_ff;
		end
	end
	assign q_o = sync_ff;
endmodule

// ==== rtl/lia_top.v ====
// logic input assertion block: one user input function from fourteen logic inputs
// assumes contact pins are asynchronous and a wishbone classic master on clk_i
`timescale 1ns/10ps
`include "lia_defines.vh"
module lia_top #(
	parameter NUM_IN = `LIA_NUM_IN,
	parameter TICK_CYC = `LIA_TICK_CYC
) (
	// clock and reset
	input wire clk_i,
	input wire rst_i,
	// wishbone slave
	input wire cyc_i,
	input wire stb_i,
	input wire we_i,
	input wire [7:0] adr_i,
	input wire [3:0] sel_i,
	input wire [31:0] dat_i,
	output reg [31:0] dat_o,
	output wire ack_o,
	// field contacts, high when closed
	input wire [NUM_IN-1:0] contact_i,
	// outputs
	output reg diag_o,
	output reg [31:0] diag_name_o,
	output reg aux_led_o,
	output reg [4:0] relay_o,
	output reg event_o,
	output wire irq_o
);
	reg [31:0] ctrl_ff;
	reg [NUM_IN-1:0] virt_ff;
	reg [15:0] delay_ff;
	reg [31:0] name_ff;
	reg [1:0] irq_stat_ff;
	reg [1:0] irq_mask_ff;
	reg [15:0] evcnt_ff;
	reg ack_ff;
	reg cond_ff;
	reg active_ff;
	reg [31:0] tick_cnt_ff;
	reg [15:0] dly_cnt_ff;
	reg [31:0] nxt_rd;
	reg raw_cond;

	wire [NUM_IN-1:0] contact_s;
	wire [3:0] src = ctrl_ff[`LIA_CTRL_SRC_MSB:`LIA_CTRL_SRC_LSB];
	wire [3:0] mode = ctrl_ff[`LIA_CTRL_MODE_MSB:`LIA_CTRL_MODE_LSB];
	wire [1:0] func = ctrl_ff[`LIA_CTRL_FUNC_MSB:`LIA_CTRL_FUNC_LSB];
	wire [4:0] rly_sel = ctrl_ff[`LIA_CTRL_RLY_MSB:`LIA_CTRL_RLY_LSB];
	wire src_ok = (src < NUM_IN);
	wire closed = src_ok & contact_s[src];
	wire von = src_ok & virt_ff[src];
	wire bus_req = cyc_i & stb_i & ~ack_ff;
	wire bus_wr = bus_req & we_i;

	lia_sync #(
		.W(NUM_IN)
	) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i(contact_i),
		.q_o(contact_s)
	);

	// byte-lane merge for writes
	function [31:0] wmerge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0] sel;
		integer i;
		begin
			wmerge = old;
			for (i = 0; i < 4; i = i + 1) begin
				if (sel[i]) begin
					wmerge[i*8 +: 8] = nw[i*8 +: 8];
				end
			end
		end
	endfunction

	// merged write words; only the implemented low bits are kept
	wire [31:0] virt_wr = wmerge({{(32-NUM_IN){1'b0}}, virt_ff}, dat_i, sel_i);
	wire [31:0] delay_wr = wmerge({16'h0000, delay_ff}, dat_i, sel_i);

	always @* begin
		case (mode)
			`LIA_MODE_CLOSE: raw_cond = closed;
			`LIA_MODE_OPEN: raw_cond = ~closed;
			`LIA_MODE_VON: raw_cond = von;
			`LIA_MODE_VOFF: raw_cond = ~von;
			`LIA_MODE_C_AND_VON: raw_cond = closed & von;
			`LIA_MODE_C_AND_VOFF: raw_cond = closed & ~von;
			`LIA_MODE_O_AND_VON: raw_cond = ~closed & von;
			`LIA_MODE_O_AND_VOFF: raw_cond = ~closed & ~von;
			`LIA_MODE_C_OR_VON: raw_cond = closed | von;
			`LIA_MODE_C_OR_VOFF: raw_cond = closed | ~von;
			`LIA_MODE_O_OR_VON: raw_cond = ~closed | von;
			`LIA_MODE_O_OR_VOFF: raw_cond = ~closed | ~von;
			default: raw_cond = 1'b0;
		endcase
		// an unselectable source never asserts
		if (!src_ok) begin
			raw_cond = 1'b0;
		end
	end

	// delay counts 10 ms ticks; the tick divider restarts with each new assertion
	wire tick = (tick_cnt_ff == TICK_CYC - 1);
	wire cond = raw_cond & (func != `LIA_FUNC_DISABLED);
	wire fire = cond & ~active_ff & (dly_cnt_ff >= delay_ff);
	wire release_ev = ~cond & active_ff;

	always @(posedge clk_i) begin
		if (rst_i) begin
			cond_ff <= 1'b0;
			active_ff <= 1'b0;
			tick_cnt_ff <= 32'h00000000;
			dly_cnt_ff <= 16'h0000;
		end else begin
			cond_ff <= cond;
			if (!cond) begin
				tick_cnt_ff <= 32'h00000000;
				dly_cnt_ff <= 16'h0000;
				active_ff <= 1'b0;
			end else begin
				if (fire) begin
					active_ff <= 1'b1;
				end
				if (tick) begin
					tick_cnt_ff <= 32'h00000000;
					if (dly_cnt_ff != 16'hffff) begin
						dly_cnt_ff <= dly_cnt_ff + 16'h0001;
					end
				end else begin
					tick_cnt_ff <= tick_cnt_ff + 32'h00000001;
				end
			end
		end
	end

	// outputs follow the active state; only alarm drives the indications
	always @(posedge clk_i) begin
		if (rst_i) begin
			diag_o <= 1'b0;
			diag_name_o <= 32'h00000000;
			aux_led_o <= 1'b0;
			relay_o <= 5'h00;
			event_o <= 1'b0;
		end else begin
			event_o <= fire;
			if (fire && func == `LIA_FUNC_ALARM) begin
				diag_o <= 1'b1;
				diag_name_o <= name_ff;
				aux_led_o <= 1'b1;
				relay_o <= rly_sel;
			end else if (!cond) begin
				diag_o <= 1'b0;
				aux_led_o <= 1'b0;
				relay_o <= 5'h00;
			end
		end
	end

	// register file
	always @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_ff <= `LIA_CTRL_RST;
			virt_ff <= {NUM_IN{1'b0}};
			delay_ff <= 16'h0000;
			name_ff <= `LIA_NAME_RST;
			irq_stat_ff <= 2'h0;
			irq_mask_ff <= 2'h0;
			evcnt_ff <= 16'h0000;
			ack_ff <= 1'b0;
			dat_o <= 32'h00000000;
		end else begin
			ack_ff <= bus_req;
			if (bus_req) begin
				dat_o <= nxt_rd;
			end
			if (bus_wr) begin
				case (adr_i)
					`LIA_ADR_CTRL: ctrl_ff <= wmerge(ctrl_ff, dat_i, sel_i);
					`LIA_ADR_VIRT: virt_ff <= virt_wr[NUM_IN-1:0];
					`LIA_ADR_DELAY: delay_ff <= delay_wr[15:0];
					`LIA_ADR_NAME: name_ff <= wmerge(name_ff, dat_i, sel_i);
					`LIA_ADR_IRQ_MASK: irq_mask_ff <= sel_i[0] ? dat_i[1:0] : irq_mask_ff;
					default: ;
				endcase
			end
			// set wins over a write-one clear in the same cycle
			irq_stat_ff <= (irq_stat_ff & ~((bus_wr && adr_i == `LIA_ADR_IRQ_STAT && sel_i[0])
				? dat_i[1:0] : 2'h0)) | {release_ev, fire};
			if (fire) begin
				evcnt_ff <= evcnt_ff + 16'h0001;
			end
		end
	end

	always @* begin
		nxt_rd = 32'h00000000;
		case (adr_i)
			`LIA_ADR_CTRL: nxt_rd = ctrl_ff;
			`LIA_ADR_VIRT: nxt_rd[NUM_IN-1:0] = virt_ff;
			`LIA_ADR_DELAY: nxt_rd[15:0] = delay_ff;
			`LIA_ADR_CONTACT: nxt_rd[NUM_IN-1:0] = contact_s;
			`LIA_ADR_STATUS: nxt_rd = {29'h0, active_ff, cond_ff, raw_cond};
			`LIA_ADR_IRQ_STAT: nxt_rd[1:0] = irq_stat_ff;
			`LIA_ADR_IRQ_MASK: nxt_rd[1:0] = irq_mask_ff;
			`LIA_ADR_EVCNT: nxt_rd[15:0] = evcnt_ff;
			`LIA_ADR_NAME: nxt_rd = name_ff;
			default: nxt_rd = 32'h00000000;
		endcase
	end

	assign ack_o = ack_ff;
	assign irq_o = |(irq_stat_ff & irq_mask_ff);
endmodule

// ==== test/lia_field.sv ====
// field contact model driving the contact pins
// assumes want_i changes just after clk_i rises
`timescale 1ns/10ps
module lia_field (
	// clock
	input wire clk_i,
	// wanted and driven contact states
	input wire [13:0] want_i,
	output reg [13:0] pin_o
);
	initial pin_o = 14'h0000;
	always @(posedge clk_i) begin
		pin_o <= want_i;
	end
endmodule

// ==== test/lia_top_props.sv ====
// checker of the logic input block ports
// assumes one clock, bound to lia_top
`timescale 1ns/10ps
module lia_props (
	input wire clk_i,
	input wire rst_i,
	input wire cyc_i,
	input wire stb_i,
	input wire ack_o,
	input wire diag_o,
	input wire [31:0] diag_name_o,
	input wire aux_led_o,
	input wire [4:0] relay_o,
	input wire event_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_ack; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
	a_ack: assert property (p_ack) else $error("ack late");
	property p_one; ack_o |=> !ack_o; endproperty
	a_one: assert property (p_one) else $error("ack long");
	property p_idle; !(cyc_i && stb_i) |=> !ack_o; endproperty
	a_idle: assert property (p_idle) else $error("stray ack");
	property p_led; diag_o == aux_led_o; endproperty
	a_led: assert property (p_led) else $error("led differs");
	property p_rly; !diag_o |-> relay_o == 5'h00; endproperty
	a_rly: assert property (p_rly) else $error("relay on");
	property p_ev; $rose(diag_o) |-> event_o; endproperty
	a_ev: assert property (p_ev) else $error("no event");
	property p_evp; event_o |=> !event_o; endproperty
	a_evp: assert property (p_evp) else $error("event long");
	property p_nm; diag_o && $past(diag_o) |-> $stable(diag_name_o); endproperty
	a_nm: assert property (p_nm) else $error("name moved");
	c_ev: cover property (event_o);
	c_off: cover property ($fell(diag_o));
	c_ack: cover property (ack_o && diag_o);
endmodule
bind lia_top lia_props chk_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
	.stb_i(stb_i), .ack_o(ack_o), .diag_o(diag_o), .diag_name_o(diag_name_o),
	.aux_led_o(aux_led_o), .relay_o(relay_o), .event_o(event_o));

// ==== test/lia_top_test.sv ====
// self-checking bench of the logic input block
// assumes a short tick and the field model on the contacts
`timescale 1ns/10ps
`include "lia_defines.vh"
module lia_top_test;
	reg clk_i = 1'b0;
	reg rst_i = 1'b1;
	reg cyc_i = 1'b0;
	reg stb_i = 1'b0;
	reg we_i = 1'b0;
	reg [7:0] adr_i = 8'h00;
	reg [3:0] sel_i = 4'hf;
	reg [31:0] dat_i = 32'h00000000;
	reg [13:0] want = 14'h0000;
	reg [31:0] rd;
	reg c, v, e;
	reg pe = 1'b0;
	integer failures = 0, checked = 0, evn = 0, evp = 0, m, k;
	wire [13:0] pins;
	wire [31:0] dat_o, name;
	wire [4:0] rly;
	wire ack_o, diag, led, ev, irq;
	lia_top #(.TICK_CYC(4)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
		.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
		.sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.contact_i(pins), .diag_o(diag), .diag_name_o(name),
		.aux_led_o(led), .relay_o(rly), .event_o(ev), .irq_o(irq));
	lia_field fld_u (.clk_i(clk_i), .want_i(want), .pin_o(pins));
	initial forever #5 clk_i = ~clk_i;
	// counts event pulses as the log would see them
	always @(posedge clk_i)
		if (ev === 1'b1)
			evp <= evp + 1;
	task test_done;
		begin
			$display("checked %0d failures %0d", checked, failures);
			if (failures == 0 && checked > 0)
				$display("ALL CHECKS OK");
			else
				$display("CHECKS NOT OK");
			$finish;
		end
	endtask
	task cmp(input [63:0] s, input [31:0] x, input [31:0] g);
		begin
			checked = checked + 1;
			if (x !== g) begin
				failures = failures + 1;
				$display("mismatch %0s exp %h got %h", s, x, g);
			end
		end
	endtask
	task bus(input w, input [7:0] a, input [31:0] d);
		integer n;
		begin
			@(posedge clk_i);
			cyc_i <= 1'b1;
			stb_i <= 1'b1;
			we_i <= w;
			adr_i <= a;
			dat_i <= d;
			for (n = 0; n < 20 && ack_o !== 1'b1; n = n + 1)
				@(posedge clk_i);
			rd = dat_o;
			cyc_i <= 1'b0;
			stb_i <= 1'b0;
			if (n == 20) begin
				failures = failures + 1;
				test_done;
			end
		end
	endtask
	// a and b terms, then and or or of them by mode
	function f(input [3:0] md, input cc, input vv);
		case (md)
			4'h0: f = cc;
			4'h1: f = !cc;
			4'h2: f = vv;
			4'h3: f = !vv;
			4'h4, 4'h5, 4'h6, 4'h7: f = (cc ^ md[1]) & (vv ^ md[0]);
			4'h8, 4'h9, 4'ha, 4'hb: f = (cc ^ md[1]) | (vv ^ md[0]);
			default: f = 1'b0;
		endcase
	endfunction
	task chk;
		begin
			repeat (8) @(posedge clk_i);
			e = f(m[3:0], c, v);
			if (e && !pe)
				evn = evn + 1;
			pe = e;
			cmp("diag", e, diag);
			cmp("led", e, led);
			cmp("relay", e, rly);
			if (e)
				cmp("name", 32'h0000a5c3, name);
		end
	endtask
	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		bus(1, `LIA_ADR_NAME, 32'h0000a5c3);
		c = 0;
		v = 0;
		// other inputs sit opposite to the source to expose a wrong pick
		for (m = 0; m < 12; m = m + 1) begin
			bus(1, `LIA_ADR_CTRL, {11'h000, 5'h01, 6'h00, 2'h1, m[3:0], 4'h5});
			chk;
			for (k = 0; k < 4; k = k + 1) begin
				{c, v} = k[1:0] ^ k[2:1];
				bus(1, `LIA_ADR_VIRT, v ? 32'h20 : 32'h3fdf);
				want <= c ? 14'h0020 : 14'h3fdf;
				chk;
			end
		end
		bus(0, `LIA_ADR_EVCNT, 0);
		cmp("evcnt", evn, rd);
		bus(0, `LIA_ADR_CONTACT, 0);
		cmp("contact", 32'h0020, rd);
		bus(0, `LIA_ADR_VIRT, 0);
		cmp("virt", 32'h3fdf, rd);
		bus(0, 8'hfc, 0);
		cmp("unmap", 0, rd);
		bus(1, `LIA_ADR_IRQ_MASK, 1);
		bus(0, `LIA_ADR_IRQ_STAT, 0);
		cmp("istat", 3, rd);
		cmp("irq", 1, irq);
		bus(1, `LIA_ADR_IRQ_STAT, 3);
		cmp("irqclr", 0, irq);
		bus(1, `LIA_ADR_DELAY, 2);
		bus(1, `LIA_ADR_CTRL, 32'h00010125);
		bus(1, `LIA_ADR_VIRT, 32'h20);
		for (k = 0; k < 40 && diag !== 1'b1; k = k + 1)
			@(posedge clk_i);
		cmp("delay", 2 * 4 + 1, k);
		// log-only function logs the event but lights nothing
		bus(1, `LIA_ADR_VIRT, 32'h0);
		bus(1, `LIA_ADR_DELAY, 0);
		bus(1, `LIA_ADR_CTRL, 32'h00010225);
		bus(1, `LIA_ADR_VIRT, 32'h20);
		@(posedge clk_i);
		cmp("event", 1, ev);
		repeat (4) @(posedge clk_i);
		cmp("logdiag", 0, diag);
		cmp("logrly", 0, rly);
		// undefined mode codes never assert
		bus(1, `LIA_ADR_CTRL, 32'h000101c5);
		bus(0, `LIA_ADR_STATUS, 0);
		cmp("status", 0, rd);
		bus(0, `LIA_ADR_EVCNT, 0);
		cmp("evcnt2", evn + 2, rd);
		cmp("evpulse", evn + 2, evp);
		// a reset in mid-run returns the registers and outputs to idle
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		bus(0, `LIA_ADR_CTRL, 0);
		cmp("ctrlrst", 0, rd);
		cmp("diagrst", 0, diag);
		test_done;
	end
endmodule
